/* File: dv/cefc_top_test.sv */
// testbench: random and corner stimulus for the charger event flags over axi4-lite
// assumes: cefc_pkg and cefc_top compiled first; ce mostly high, wstrb all ones
`timescale 1ns/1ps
module cefc_top_test;
  logic        aclk    = 1'b0;
  logic        aresetn = 1'b0;
  logic [5:0]  pins    = 6'h00;  // in2, pgood, weak, wdog, boost, vin
  logic [3:0]  awaddr  = 4'h0;
  logic [3:0]  araddr  = 4'h0;
  logic [31:0] wdata   = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid  = 1'b0;
  logic        bready  = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready  = 1'b0;
  logic        ce      = 1'b1;
  logic        awready, wready, bvalid, arready, rvalid, irq;
  logic [31:0] rdata, rd;
  logic [1:0]  bresp, rresp, rs;
  logic [4:0]  expf    = 5'h00;
  int          fails   = 0;
  int          checked = 0;

  cefc_top uut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .input_voltage_regulation(pins[0]), .boost_output_voltage_regulation(pins[1]),
    .watchdog_expired(pins[2]), .weak_source_status(pins[3]),
    .power_good_status(pins[4]), .second_input_present(pins[5]),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .irq(irq));

  // free-running 125 mhz clock
  always #4 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and compares
  task automatic summarize;
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic cmpd(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t value %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmpr(input logic [1:0] g, input logic [1:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %0t response %h expected %h", $time, g, e);
    end
  endtask

  task automatic hang;
    fails++;
    $display("[ERR] %0t bus answer never came", $time);
    summarize();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // axi4-lite master: hold each channel until its own handshake edge
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) begin
        rs = bresp;
        bready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (int n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
        return;
      end
    end
    hang();
  endtask

  // flag read against the bench's accumulated events, then forget them
  task automatic rflag;
    rdr(cefc_pkg::FLAG_OFS);
    cmpd(rd, {27'h0, expf});
    cmpr(rs, cefc_pkg::RESP_OKAY);
    expf = 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // stimulus helpers: expected events, pin steps, reset
  function automatic logic [4:0] ev(input logic [5:0] p, input logic [5:0] c);
    ev[0] = ~(p[0] | p[1]) & (c[0] | c[1]);
    ev[1] = ~p[2] & c[2];
    ev[2] = ~p[3] & c[3];
    ev[3] = p[4] ^ c[4];
    ev[4] = p[5] ^ c[5];
  endfunction

  // live status levels expected from settled pins
  function automatic logic [4:0] lvl(input logic [5:0] p);
    lvl = {p[5], p[4], p[3], p[2], p[0] | p[1]};
  endfunction

  // long settle covers the synchroniser and flag latency
  task automatic step(input logic [5:0] v);
    @(posedge aclk);
    expf = expf | ev(pins, v);
    pins <= v;
    repeat (8) @(posedge aclk);
  endtask

  task automatic rstall;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    expf = 5'h00;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    void'($urandom(32'h63a1534c));
    rstall();
    rflag();
    rdr(cefc_pkg::MASK_OFS);
    cmpd(rd, 32'h0);
    repeat (30) begin
      step(6'($urandom));
      step(6'($urandom));
      rdr(cefc_pkg::STATUS_OFS);
      cmpd(rd, {27'h0, lvl(pins)});
      rflag();
      rflag();
    end
    step(6'h00);
    rflag();
    step(6'h01);
    step(6'h03);
    step(6'h02);
    step(6'h00);
    rflag();
    wr(cefc_pkg::MASK_OFS, 32'hfffffffb);
    step(6'h08);
    cmpd({31'h0, irq}, 32'h0);
    wr(cefc_pkg::MASK_OFS, 32'h00000004);
    repeat (3) @(posedge aclk);
    cmpd({31'h0, irq}, 32'h1);
    rflag();
    repeat (3) @(posedge aclk);
    cmpd({31'h0, irq}, 32'h0);
    step(6'h18);
    wr(cefc_pkg::FLAG_OFS, 32'h0);
    cmpr(rs, cefc_pkg::RESP_OKAY);
    rflag();
    rdr(4'hc);
    cmpd(rd, 32'h0);
    cmpr(rs, cefc_pkg::RESP_SLVERR);
    wr(4'hc, 32'h1f);
    cmpr(rs, cefc_pkg::RESP_SLVERR);
    step(6'h00);
    // a watchdog pulse while ce is low must leave no trace
    ce <= 1'b0;
    @(posedge aclk);
    pins <= 6'h04;
    repeat (4) @(posedge aclk);
    pins <= 6'h00;
    @(posedge aclk);
    ce <= 1'b1;
    step(6'h00);
    rflag();
    rstall();
    repeat (4) @(posedge aclk);
    rflag();
    summarize();
  end
endmodule

/* File: hdl/cefc_edge.sv */
// edge detector: two-flop synchroniser then rising or any-change detection
// assumes: src is asynchronous to aclk; ce freezes all state
`timescale 1ns/1ps
module cefc_edge #(
  parameter cefc_pkg::cefc_edge_e KIND = cefc_pkg::CEFC_RISE
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic src,
  output logic      level,
  output logic      pulse
);

  typedef struct packed {
    logic s1;   // first synchroniser stage
    logic s2;   // second stage, only reader of s1
    logic s3;   // previous synchronised value
  } cefc_edge_s;

  cefc_edge_s st_r;
  cefc_edge_s st_nxt;

  // shift the synchroniser chain
  always_comb begin
    st_nxt    = st_r;
    if (ce) begin
      st_nxt.s1 = src;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // detect the edge from the two synchronised samples
  assign level = st_r.s2;
  assign pulse = ce && ((KIND == cefc_pkg::CEFC_ANY) ? (st_r.s2 ^ st_r.s3)
                                                     : (st_r.s2 & ~st_r.s3));

endmodule

/* File: hdl/cefc_pkg.sv */
// package: register map and field layout of the charger event flag block
// assumes: a 32-bit axi4-lite slave reaches the registers
package cefc_pkg;

  // register byte offsets
  localparam logic [3:0] FLAG_OFS   = 4'h0;  // sticky event flags, read clears
  localparam logic [3:0] MASK_OFS   = 4'h4;  // interrupt mask, 1 enables
  localparam logic [3:0] STATUS_OFS = 4'h8;  // live synchronised status levels

  // field positions, shared by flag, mask and status registers
  localparam int BIT_VREG  = 0;  // input_voltage_regulation or boost regulation
  localparam int BIT_WDOG  = 1;  // watchdog expiry
  localparam int BIT_WEAK  = 2;  // weak source detection
  localparam int BIT_PGOOD = 3;  // power_good_status
  localparam int BIT_IN2   = 4;  // second input presence
  localparam int NUM_EV    = 5;

  // reset values
  localparam logic [NUM_EV-1:0] FLAG_RST = 5'h00;
  localparam logic [NUM_EV-1:0] MASK_RST = 5'h00;

  // axi response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // kind of edge each event detects
  typedef enum logic {
    CEFC_RISE,
    CEFC_ANY
  } cefc_edge_e;

endpackage

/* File: hdl/cefc_top.sv */
// top: charger event flag capture with axi4-lite register access
// assumes: status inputs are asynchronous levels; one clock aclk at 125 MHz
//
// The AXI4-Lite interface to the registers and the address map are this design's own decisions.
`timescale 1ns/1ps
module cefc_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        input_voltage_regulation,
  input  wire logic        boost_output_voltage_regulation,
  input  wire logic        watchdog_expired,
  input  wire logic        weak_source_status,
  input  wire logic        power_good_status,
  input  wire logic        second_input_present,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic             irq
);

  localparam int N = cefc_pkg::NUM_EV;

  typedef struct packed {
    logic         aw_got;   // write address captured
    logic [3:0]   aw_addr;
    logic         w_got;    // write data captured
    logic [31:0]  w_data;
    logic [3:0]   w_strb;
    logic         bvalid;
    logic [1:0]   bresp;
    logic         rvalid;
    logic [31:0]  rdata;
    logic [1:0]   rresp;
    logic [N-1:0] flag;     // sticky event flags
    logic [N-1:0] mask;
    logic         irq;
  } cefc_top_s;

  cefc_top_s st_r;
  cefc_top_s st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // event sources and edge detectors

  logic [N-1:0] ev_src;
  logic [N-1:0] ev_lvl;
  logic [N-1:0] ev_pulse;

  // regulation is either input or boost loop active
  assign ev_src[cefc_pkg::BIT_VREG]  = input_voltage_regulation | boost_output_voltage_regulation;
  assign ev_src[cefc_pkg::BIT_WDOG]  = watchdog_expired;
  assign ev_src[cefc_pkg::BIT_WEAK]  = weak_source_status;
  assign ev_src[cefc_pkg::BIT_PGOOD] = power_good_status;
  assign ev_src[cefc_pkg::BIT_IN2]   = second_input_present;

  // one detector per event; power good and presence detect both directions
  genvar gi;
  generate
    for (gi = 0; gi < N; gi++) begin : g_ev
      localparam cefc_pkg::cefc_edge_e K =
        (gi == cefc_pkg::BIT_PGOOD || gi == cefc_pkg::BIT_IN2) ? cefc_pkg::CEFC_ANY
                                                               : cefc_pkg::CEFC_RISE;
      cefc_edge #(.KIND(K)) u_edge (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .src     (ev_src[gi]),
        .level   (ev_lvl[gi]),
        .pulse   (ev_pulse[gi])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus handshakes and next state

  logic         aw_hs;
  logic         w_hs;
  logic         ar_hs;
  logic         do_wr;
  logic         rd_flag;
  logic [31:0]  rd_val;
  logic         rd_ok;

  assign aw_hs   = ce && s_axi_awvalid && !st_r.aw_got;
  assign w_hs    = ce && s_axi_wvalid && !st_r.w_got;
  assign ar_hs   = ce && s_axi_arvalid && !st_r.rvalid;
  assign do_wr   = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rd_flag = ar_hs && (s_axi_araddr == cefc_pkg::FLAG_OFS);

  // read multiplexer, unused upper bits read zero
  always_comb begin
    rd_val = 32'h0000_0000;
    rd_ok  = 1'b1;
    unique case (s_axi_araddr)
      cefc_pkg::FLAG_OFS:   rd_val[N-1:0] = st_r.flag;
      cefc_pkg::MASK_OFS:   rd_val[N-1:0] = st_r.mask;
      cefc_pkg::STATUS_OFS: rd_val[N-1:0] = ev_lvl;
      default:              rd_ok = 1'b0;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    if (ce) begin
      // capture address and data in either order
      if (aw_hs) begin
        st_nxt.aw_got  = 1'b1;
        st_nxt.aw_addr = s_axi_awaddr;
      end
      if (w_hs) begin
        st_nxt.w_got  = 1'b1;
        st_nxt.w_data = s_axi_wdata;
        st_nxt.w_strb = s_axi_wstrb;
      end
      // perform the write once both halves are here
      if (do_wr) begin
        st_nxt.bvalid = 1'b1;
        st_nxt.bresp  = cefc_pkg::RESP_OKAY;
        if (st_r.aw_addr == cefc_pkg::MASK_OFS) begin
          if (st_r.w_strb[0]) begin
            st_nxt.mask = st_r.w_data[N-1:0];
          end
        end else if (st_r.aw_addr != cefc_pkg::FLAG_OFS &&
                     st_r.aw_addr != cefc_pkg::STATUS_OFS) begin
          st_nxt.bresp = cefc_pkg::RESP_SLVERR;
        end
      end
      if (st_r.bvalid && s_axi_bready) begin
        st_nxt.bvalid = 1'b0;
        st_nxt.aw_got = 1'b0;
        st_nxt.w_got  = 1'b0;
      end
      // read answer one cycle after address
      if (ar_hs) begin
        st_nxt.rvalid = 1'b1;
        st_nxt.rdata  = rd_val;
        st_nxt.rresp  = rd_ok ? cefc_pkg::RESP_OKAY : cefc_pkg::RESP_SLVERR;
      end else if (st_r.rvalid && s_axi_rready) begin
        st_nxt.rvalid = 1'b0;
      end
      // flags: read clears, a new event in the same cycle wins
      st_nxt.flag = (rd_flag ? '0 : st_r.flag) | ev_pulse;
      st_nxt.irq  = |(st_nxt.flag & st_nxt.mask);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r      <= '0;
      st_r.flag <= cefc_pkg::FLAG_RST;
      st_r.mask <= cefc_pkg::MASK_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from state

  assign s_axi_awready = st_r.aw_got == 1'b0;
  assign s_axi_wready  = st_r.w_got == 1'b0;
  assign s_axi_bvalid  = st_r.bvalid;
  assign s_axi_bresp   = st_r.bresp;
  assign s_axi_arready = st_r.rvalid == 1'b0;
  assign s_axi_rvalid  = st_r.rvalid;
  assign s_axi_rdata   = st_r.rdata;
  assign s_axi_rresp   = st_r.rresp;
  assign irq           = st_r.irq;

  ////////////////////////////////////////////////////////////////////////////
  // assertions

  sequence rise_seen(int b);
    ce && ev_lvl[b] && !$past(ev_lvl[b]) && $past(ce);
  endsequence

  AST_VREG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_seen(cefc_pkg::BIT_VREG) |=> st_r.flag[cefc_pkg::BIT_VREG])
    else $error("regulation flag not set after edge");

  AST_WDOG_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_seen(cefc_pkg::BIT_WDOG) |=> st_r.flag[cefc_pkg::BIT_WDOG])
    else $error("watchdog flag not set after rising edge");

  AST_WEAK_SET: assert property (@(posedge aclk) disable iff (!aresetn)
    rise_seen(cefc_pkg::BIT_WEAK) |=> st_r.flag[cefc_pkg::BIT_WEAK])
    else $error("weak source flag not set after rising edge");

  AST_PGOOD_ANY: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && $past(ce) && $changed(ev_lvl[cefc_pkg::BIT_PGOOD]))
    |=> st_r.flag[cefc_pkg::BIT_PGOOD])
    else $error("power good flag missed a change");

  AST_IN2_ANY: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && $past(ce) && $changed(ev_lvl[cefc_pkg::BIT_IN2]))
    |=> st_r.flag[cefc_pkg::BIT_IN2])
    else $error("presence flag missed a change");

  AST_FLAG_HOLD: assert property (@(posedge aclk) disable iff (!aresetn)
    (|st_r.flag && !rd_flag) |=> ((st_r.flag & $past(st_r.flag)) == $past(st_r.flag)))
    else $error("flag dropped without a read");

  AST_RISE_ONLY: assert property (@(posedge aclk) disable iff (!aresetn)
    (ce && !ev_lvl[cefc_pkg::BIT_WEAK] && $past(ev_lvl[cefc_pkg::BIT_WEAK])
     && !st_r.flag[cefc_pkg::BIT_WEAK]) |=> !st_r.flag[cefc_pkg::BIT_WEAK])
    else $error("weak source flag set on falling edge");

  AST_READ_CLR: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_flag && ev_pulse == '0) |=> (st_r.flag == '0) ##0 (s_axi_rvalid))
    else $error("flag read did not clear flags");

endmodule
